/* File: design/mapper_pkg.sv */
package mapper_pkg;
    localparam int CLOCK_HZ = 200_000_000;
    localparam int BAUD_SLOW = 9600;
    localparam int BAUD_FAST = 57600;
    localparam int SLOW_BIT_CYCLES = CLOCK_HZ / BAUD_SLOW;
    localparam int FAST_BIT_CYCLES = CLOCK_HZ / BAUD_FAST;
    localparam int POLL_PERIOD_MS = 10;
    localparam int POLL_CYCLES = (CLOCK_HZ / 1000) * POLL_PERIOD_MS;
    localparam int BIT_CNT_W = 16;
    localparam int DATA_BITS = 8;

    localparam logic [3:0] SEL_IMAGER = 4'h7;
    localparam logic [3:0] SEL_SCANNER = 4'h8;
    localparam logic [3:0] SEL_RFID = 4'h9;
    localparam logic [3:0] SEL_POSITION = 4'hA;

    localparam logic [7:0] CH_STX = 8'h02;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_VERSION = 8'h76;
    localparam logic [7:0] CH_PLUS = 8'h2B;
    localparam logic [7:0] CH_MINUS = 8'h2D;
    localparam logic [7:0] CH_PARAM_RESET = 8'h52;
    localparam logic [7:0] CH_RESTART = 8'h48;
    localparam logic [7:0] POS_CODE_BASE = 8'h01;
    localparam logic [7:0] POS_REQ_CODE = 8'h08;

    localparam int CB_VERSION = 0;
    localparam int CB_GATE = 1;
    localparam int CB_POS_REQ = 3;
    localparam int CB_PARAM_RESET = 14;
    localparam int CB_RESTART = 15;
    localparam logic [15:0] MASK_IMAGER = 16'h0003;
    localparam logic [15:0] MASK_RFID = 16'hC003;
    localparam logic [15:0] MASK_POSITION = 16'h001F;
    localparam logic [15:0] MASK_POS_OTHER = 16'h0017;
    localparam logic [15:0] MASK_GATE = 16'h0002;
    localparam logic [15:0] MASK_PARAM_RESET = 16'h4000;

    localparam logic [11:0] ADDR_MODE = 12'h000;
    localparam logic [11:0] ADDR_CONTROL = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam int MODE_CMD_BIT = 0;
    localparam int MODE_BRIDGED_BIT = 1;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_AUTO_BIT = 1;
    localparam int STAT_FAST_BIT = 2;
    localparam int STAT_PROFILE_LSB = 4;
    localparam int STAT_PENDING_LSB = 16;
endpackage

/* File: design/tx_byte_if.sv */
`timescale 1ns/1ps
interface tx_byte_if;
    logic [7:0] data;
    logic valid;
    logic ready;
    logic [15:0] bit_cycles;
    modport src (output data, output valid, output bit_cycles, input ready);
    modport snk (input data, input valid, input bit_cycles, output ready);
endinterface

/* File: design/uart_tx.sv */
`timescale 1ns/1ps
module uart_tx
    import mapper_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    tx_byte_if.snk tx,
    output logic txd
);
    typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_START = 2'b01, TX_DATA = 2'b10, TX_STOP = 2'b11} tx_state_t;
    tx_state_t state_ff, nxt_state;
    logic [7:0] shift_ff, nxt_shift;
    logic [2:0] bit_ff, nxt_bit;
    logic [BIT_CNT_W-1:0] cyc_ff, nxt_cyc;
    logic txd_ff, nxt_txd;
    logic bit_end;

    // ready only in idle, so the stop bit is always complete before the next byte
    assign tx.ready = (state_ff == TX_IDLE);
    assign txd = txd_ff;
    assign bit_end = (cyc_ff == tx.bit_cycles - 16'h0001);

    always_comb begin
        nxt_state = state_ff;
        nxt_shift = shift_ff;
        nxt_bit = bit_ff;
        nxt_cyc = bit_end ? 16'h0000 : cyc_ff + 16'h0001;
        nxt_txd = txd_ff;
        case (state_ff)
            TX_IDLE: begin
                nxt_cyc = 16'h0000;
                nxt_txd = 1'b1;
                if (tx.valid) begin
                    nxt_shift = tx.data;
                    nxt_txd = 1'b0;
                    nxt_state = TX_START;
                end
            end
            TX_START: begin
                if (bit_end) begin
                    nxt_txd = shift_ff[0];
                    nxt_bit = 3'h0;
                    nxt_state = TX_DATA;
                end
            end
            TX_DATA: begin
                if (bit_end) begin
                    nxt_bit = bit_ff + 3'h1;
                    nxt_shift = {1'b0, shift_ff[7:1]};
                    nxt_txd = shift_ff[1];
                    if (bit_ff == 3'(DATA_BITS - 1)) begin
                        nxt_txd = 1'b1;
                        nxt_state = TX_STOP;
                    end
                end
            end
            TX_STOP: begin
                if (bit_end) begin
                    nxt_state = TX_IDLE;
                end
            end
            default: nxt_state = TX_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= TX_IDLE;
            shift_ff <= 8'h00;
            bit_ff <= 3'h0;
            cyc_ff <= 16'h0000;
            txd_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            shift_ff <= nxt_shift;
            bit_ff <= nxt_bit;
            cyc_ff <= nxt_cyc;
            txd_ff <= nxt_txd;
        end
    end
endmodule // uart_tx

/* File: design/poll_timer.sv */
`timescale 1ns/1ps
module poll_timer #(
    parameter int PERIOD = 2_000_000,
    parameter int CNT_W = 24
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic enable,
    output logic tick
);
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic tick_ff, nxt_tick;

    initial begin
        if (PERIOD < 2 || PERIOD > (2 ** CNT_W)) begin
            $error("poll_timer: period does not fit the counter");
        end
    end

    assign tick = tick_ff;

    always_comb begin
        nxt_tick = 1'b0;
        nxt_cnt = cnt_ff + 1'b1;
        if (!enable) begin
            nxt_cnt = '0;
        end else if (cnt_ff == CNT_W'(PERIOD - 1)) begin
            nxt_cnt = '0;
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end
endmodule // poll_timer

/* File: design/serial_profile_command_mapper.sv */
// Function
// - commands only while command mode bit set
// - profile chosen from selector positions 7,8,9,A
// - positions 7,9: 9600 8N1, STX data CR LF
// - position 7: bit0 'v', bit1 '+'
// - position 8: 9600 8N1, no commands
// - position 9: bit0 'v', bit1 '+'/'-'
// - position 9: bit14 'R', bit15 restart
// - position A: 57600 8N1, unframed binary
// - position A: bits 0-4 send doubled code
// - position A: auto position request every 10 ms
// - any other command stops auto requests
// - auto resumes on position request or restart
// - bit15 sends single-character restart; the code sends it framed as STX 'H' CR LF
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
module serial_profile_command_mapper
    import mapper_pkg::*;
#(
    parameter int SLOW_CYCLES = SLOW_BIT_CYCLES,
    parameter int FAST_CYCLES = FAST_BIT_CYCLES,
    parameter int POLL_PERIOD = POLL_CYCLES
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [3:0] profile_selector_switch,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic txd
);
    typedef enum logic [1:0] {SQ_IDLE = 2'b00, SQ_SEND = 2'b01, SQ_DRAIN = 2'b10} seq_state_t;

    initial begin
        if (SLOW_CYCLES < 2 || SLOW_CYCLES > 65535 || FAST_CYCLES < 2 || FAST_CYCLES > 65535) begin
            $error("bit time does not fit the bit counter");
        end
    end

    logic rst_meta_ff, rst_sync_ff, rst_n;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    assign rst_n = rst_sync_ff;

    tx_byte_if tx ();
    logic poll_tick;

    // register bus
    logic [1:0] mode_ff, nxt_mode;
    logic [15:0] ctl_ff, nxt_ctl;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
    logic [31:0] status;
    logic access;

    // command queue
    logic [3:0] profile_ff;
    logic [15:0] prev_ff, pend_ff, nxt_pend, rise, fall, set_mask, clr_mask;
    logic gate_dir_ff, nxt_gate_dir, auto_ff, nxt_auto, auto_pend_ff, nxt_auto_pend;
    logic [15:0] bit_cycles_ff, nxt_bit_cycles;

    // sequencer
    seq_state_t sq_ff, nxt_sq;
    logic [7:0] seq_ff [4];
    logic [7:0] nxt_seq [4];
    logic [1:0] pos_ff, nxt_pos;
    logic [2:0] len_ff, nxt_len;
    logic load, found, pick_auto, last_byte;
    logic [3:0] pick;
    logic [7:0] ch;

    assign access = psel && penable && !pready_ff;
    assign status = {pend_ff, 8'h00, profile_ff, 1'b0, (profile_ff == SEL_POSITION), auto_ff, (sq_ff != SQ_IDLE)};
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;

    always_comb begin
        nxt_mode = mode_ff;
        nxt_ctl = ctl_ff;
        nxt_prdata = prdata_ff;
        nxt_pslverr = 1'b0;
        nxt_pready = access;
        if (access) begin
            nxt_prdata = 32'h0000_0000;
            case (paddr)
                ADDR_MODE: begin
                    if (pwrite) begin
                        nxt_mode = pwdata[1:0];
                    end
                    nxt_prdata = {30'h0000_0000, mode_ff};
                end
                ADDR_CONTROL: begin
                    if (pwrite) begin
                        nxt_ctl = pwdata[15:0];
                    end
                    nxt_prdata = {16'h0000, ctl_ff};
                end
                ADDR_STATUS: nxt_prdata = status;
                default: nxt_pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff <= MODE_RESET;
            ctl_ff <= CONTROL_RESET;
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            ctl_ff <= nxt_ctl;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // lowest control bit wins; automatic polling only fills idle time
    always_comb begin
        found = 1'b0;
        pick = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (pend_ff[i]) begin
                found = 1'b1;
                pick = 4'(i);
            end
        end
    end
    assign load = (sq_ff == SQ_IDLE) && tx.ready && (found || auto_pend_ff);
    assign pick_auto = !found;

    always_comb begin
        rise = ctl_ff & ~prev_ff;
        fall = ~ctl_ff & prev_ff;
        set_mask = 16'h0000;
        if (mode_ff[MODE_CMD_BIT]) begin
            case (profile_ff)
                SEL_IMAGER: set_mask = rise & MASK_IMAGER;
                SEL_RFID: begin
                    set_mask = (rise & MASK_RFID) | (fall & MASK_GATE);
                    if (mode_ff[MODE_BRIDGED_BIT]) begin
                        set_mask = set_mask & ~MASK_PARAM_RESET;
                    end
                end
                SEL_POSITION: set_mask = rise & MASK_POSITION;
                default: set_mask = 16'h0000;
            endcase
        end
        clr_mask = 16'h0000;
        if (load && !pick_auto) begin
            clr_mask[pick] = 1'b1;
        end
        // a new edge on the bit being sent stays queued
        nxt_pend = (pend_ff & ~clr_mask) | set_mask;
        nxt_gate_dir = gate_dir_ff;
        if (set_mask[CB_GATE]) begin
            nxt_gate_dir = rise[CB_GATE];
        end
        nxt_auto = auto_ff;
        if (profile_ff == SEL_POSITION) begin
            if (|(set_mask & MASK_POS_OTHER)) begin
                nxt_auto = 1'b0;
            end else if (set_mask[CB_POS_REQ]) begin
                nxt_auto = 1'b1;
            end
        end
        nxt_auto_pend = auto_pend_ff;
        if (load && pick_auto) begin
            nxt_auto_pend = 1'b0;
        end
        if (poll_tick && auto_ff && profile_ff == SEL_POSITION) begin
            nxt_auto_pend = 1'b1;
        end
        if (!nxt_auto) begin
            nxt_auto_pend = 1'b0;
        end
        nxt_bit_cycles = (profile_ff == SEL_POSITION) ? 16'(FAST_CYCLES) : 16'(SLOW_CYCLES);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            profile_ff <= 4'h0;
            prev_ff <= 16'h0000;
            pend_ff <= 16'h0000;
            gate_dir_ff <= 1'b1;
            auto_ff <= 1'b1;
            auto_pend_ff <= 1'b0;
            bit_cycles_ff <= 16'(SLOW_CYCLES);
        end else begin
            profile_ff <= profile_selector_switch;
            prev_ff <= ctl_ff;
            pend_ff <= nxt_pend;
            gate_dir_ff <= nxt_gate_dir;
            auto_ff <= nxt_auto;
            auto_pend_ff <= nxt_auto_pend;
            bit_cycles_ff <= nxt_bit_cycles;
        end
    end

    always_comb begin
        case (pick)
            4'(CB_VERSION): ch = CH_VERSION;
            4'(CB_GATE): ch = (profile_ff == SEL_RFID && !gate_dir_ff) ? CH_MINUS : CH_PLUS;
            4'(CB_PARAM_RESET): ch = CH_PARAM_RESET;
            4'(CB_RESTART): ch = CH_RESTART;
            default: ch = CH_PLUS;
        endcase
    end

    assign last_byte = ({1'b0, pos_ff} == len_ff - 3'h1);
    assign tx.valid = (sq_ff == SQ_SEND);
    assign tx.data = seq_ff[pos_ff];
    assign tx.bit_cycles = bit_cycles_ff;

    always_comb begin
        nxt_sq = sq_ff;
        nxt_pos = pos_ff;
        nxt_len = len_ff;
        nxt_seq = seq_ff;
        case (sq_ff)
            SQ_IDLE: begin
                if (load) begin
                    nxt_pos = 2'h0;
                    nxt_sq = SQ_SEND;
                    if (pick_auto) begin
                        nxt_seq = '{POS_REQ_CODE, POS_REQ_CODE, 8'h00, 8'h00};
                        nxt_len = 3'h2;
                    end else if (profile_ff == SEL_POSITION) begin
                        nxt_seq = '{POS_CODE_BASE << pick, POS_CODE_BASE << pick, 8'h00, 8'h00};
                        nxt_len = 3'h2;
                    end else begin
                        nxt_seq = '{CH_STX, ch, CH_CR, CH_LF};
                        nxt_len = 3'h4;
                    end
                end
            end
            SQ_SEND: begin
                if (tx.ready) begin
                    nxt_pos = pos_ff + 2'h1;
                    if (last_byte) begin
                        nxt_sq = SQ_DRAIN;
                    end
                end
            end
            SQ_DRAIN: begin
                if (tx.ready) begin
                    nxt_sq = SQ_IDLE;
                end
            end
            default: nxt_sq = SQ_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sq_ff <= SQ_IDLE;
            pos_ff <= 2'h0;
            len_ff <= 3'h0;
            seq_ff <= '{8'h00, 8'h00, 8'h00, 8'h00};
        end else begin
            sq_ff <= nxt_sq;
            pos_ff <= nxt_pos;
            len_ff <= nxt_len;
            seq_ff <= nxt_seq;
        end
    end

    uart_tx u_uart_tx (
        .clock(clock),
        .rst_n(rst_n),
        .tx(tx.snk),
        .txd(txd)
    );

    poll_timer #(.PERIOD(POLL_PERIOD), .CNT_W(24)) u_poll_timer (
        .clock(clock),
        .rst_n(rst_n),
        .enable(auto_ff && profile_ff == SEL_POSITION),
        .tick(poll_tick)
    );

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_NO_CMD_WHEN_OFF: assert property (!mode_ff[MODE_CMD_BIT] |=> !(|(pend_ff & ~$past(pend_ff))))
        else $error("command queued with command mode off");
    AST_FAST_IN_POSITION: assert property (profile_ff == SEL_POSITION |=> bit_cycles_ff == 16'(FAST_CYCLES))
        else $error("position profile not at fast rate");
    AST_SLOW_ELSEWHERE: assert property (profile_ff != SEL_POSITION |=> bit_cycles_ff == 16'(SLOW_CYCLES))
        else $error("framed profile not at slow rate");
    AST_SCANNER_SILENT: assert property (profile_ff == SEL_SCANNER |=> !(|(pend_ff & ~$past(pend_ff))))
        else $error("scanner profile queued a command");
    AST_DOUBLED_CODE: assert property (load && profile_ff == SEL_POSITION |=> len_ff == 3'h2 && seq_ff[0] == seq_ff[1])
        else $error("position command not doubled");
    AST_GATE_OFF: assert property (load && !pick_auto && pick == 4'(CB_GATE)
        && profile_ff == SEL_RFID && !gate_dir_ff |=> seq_ff[1] == CH_MINUS && seq_ff[0] == CH_STX)
        else $error("gate release not sent as minus");
    AST_POLL_QUEUED: assert property (poll_tick && auto_ff && profile_ff == SEL_POSITION
        && !(|(set_mask & MASK_POS_OTHER)) |=> auto_pend_ff)
        else $error("poll tick lost");
    AST_AUTO_STOP: assert property (profile_ff == SEL_POSITION && |(set_mask & MASK_POS_OTHER)
        |=> !auto_ff && !auto_pend_ff)
        else $error("auto polling survived another command");
    AST_AUTO_RESUME: assert property ($rose(auto_ff) |-> $past(set_mask[CB_POS_REQ]))
        else $error("auto polling resumed without request");
    AST_DRAIN_WAITS: assert property (sq_ff == SQ_DRAIN && !tx.ready |=> sq_ff == SQ_DRAIN)
        else $error("next command started before stop bit");
    AST_BRIDGED_NO_RESET: assert property (mode_ff[MODE_BRIDGED_BIT] |-> !set_mask[CB_PARAM_RESET])
        else $error("parameter reset queued for bridged reader");

    COV_FRAMED: cover property (load && profile_ff == SEL_RFID ##1 sq_ff == SQ_SEND);
    COV_AUTO_SENT: cover property (load && pick_auto);
    COV_QUEUE_TWO: cover property (load && $countones(pend_ff) > 1);
    COV_AUTO_STOP: cover property ($fell(auto_ff));
endmodule // serial_profile_command_mapper

/* File: tb/serial_rx_model.sv */
`timescale 1ns/1ps
module serial_rx_model (
    input wire logic clock,
    input wire logic line,
    input wire logic [15:0] bit_cycles,
    output logic [7:0] rx_byte,
    output logic rx_stb
);
    logic [7:0] b;
    int n;
    // receive only: the reader never talks back in these profiles
    initial begin
        rx_stb = 1'b0;
        rx_byte = 8'h00;
        forever begin
            @(negedge line);
            repeat (bit_cycles / 2) @(posedge clock);
            if (line !== 1'b0) continue;
            // 8 data bits lsb first, no parity, one stop bit
            for (n = 0; n < 8; n++) begin
                repeat (bit_cycles) @(posedge clock);
                b[n] = line;
            end
            repeat (bit_cycles) @(posedge clock);
            // a broken stop bit poisons the byte so any compare fails
            if (line !== 1'b1) b = 'x;
            rx_byte <= b;
            rx_stb <= 1'b1;
            @(posedge clock);
            rx_stb <= 1'b0;
        end
    end
endmodule // serial_rx_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import mapper_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] sel = 4'h7;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, txd, er, rx_stb;
    logic [7:0] rx_byte;
    logic [15:0] mdl_bits;
    logic [7:0] rxq[$], expq[$];
    int num_errors = 0;
    int cmp_count = 0;
    int cyc = 0;

    serial_profile_command_mapper #(.SLOW_CYCLES(16), .FAST_CYCLES(8), .POLL_PERIOD(2000)) dut (
        .clock(clock), .resetn(resetn), .profile_selector_switch(sel), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd));
    serial_rx_model rx (.clock(clock), .line(txd), .bit_cycles(mdl_bits), .rx_byte(rx_byte), .rx_stb(rx_stb));

    // the far side runs at the rate the selected profile asks for
    assign mdl_bits = (sel == SEL_POSITION) ? 16'h0008 : 16'h0010;
    always #2.5 clock = ~clock;

    always @(posedge clock) begin
        if (rx_stb === 1'b1) rxq.push_back(rx_byte);
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic summarize();
        $display("comparisons=%0d mismatches=%0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // waits for the slave; a hang ends at the bench timeout
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0);
        check(rd, e);
        check({31'h0, er}, {31'h0, ee});
    endtask

    task automatic frm(input logic [7:0] c);
        expq.push_back(8'h02);
        expq.push_back(c);
        expq.push_back(8'h0D);
        expq.push_back(8'h0A);
    endtask

    task automatic dbl(input logic [7:0] c);
        expq.push_back(c);
        expq.push_back(c);
    endtask

    // quiet window after the last byte catches extra or repeated sends
    task automatic drain(input int budget, input int quiet);
        int i;
        i = 0;
        while (rxq.size() < expq.size() && i < budget) begin
            @(posedge clock);
            i++;
        end
        repeat (quiet) @(posedge clock);
        check(32'(rxq.size()), 32'(expq.size()));
        if (rxq.size() == expq.size())
            foreach (expq[k]) check({24'h0, rxq[k]}, {24'h0, expq[k]});
        rxq.delete();
        expq.delete();
    endtask

    initial begin
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        rdc(ADDR_MODE, 32'h0, 1'b0);
        rdc(ADDR_CONTROL, 32'h0, 1'b0);
        rdc(ADDR_STATUS, 32'h0000_0072, 1'b0);
        rdc(12'hFFC, 32'h0, 1'b1);
        wr(ADDR_CONTROL, 32'h3);
        drain(0, 600);
        wr(ADDR_CONTROL, 32'h0);
        wr(ADDR_MODE, 32'h1);
        wr(ADDR_CONTROL, 32'h3);
        frm(8'h76);
        frm(8'h2B);
        drain(2000, 400);
        wr(ADDR_CONTROL, 32'h0);
        drain(0, 600);
        sel <= SEL_SCANNER;
        wr(ADDR_CONTROL, 32'hFFFF);
        drain(0, 600);
        wr(ADDR_CONTROL, 32'h0);
        // a selector position with no profile ignores the control word
        sel <= 4'hB;
        wr(ADDR_CONTROL, 32'hFFFF_0003);
        rdc(ADDR_CONTROL, 32'h0000_0003, 1'b0);
        drain(0, 600);
        wr(ADDR_CONTROL, 32'h0);
        sel <= SEL_RFID;
        wr(ADDR_CONTROL, 32'hC002);
        frm(8'h2B);
        frm(8'h52);
        frm(CH_RESTART);
        drain(3000, 400);
        wr(ADDR_CONTROL, 32'h0);
        frm(8'h2D);
        drain(1000, 400);
        wr(ADDR_MODE, 32'h3);
        wr(ADDR_CONTROL, 32'hC001);
        frm(8'h76);
        frm(CH_RESTART);
        drain(2000, 400);
        wr(ADDR_MODE, 32'h0);
        wr(ADDR_CONTROL, 32'h0);
        sel <= SEL_POSITION;
        dbl(8'h08);
        drain(2600, 300);
        wr(ADDR_MODE, 32'h1);
        wr(ADDR_CONTROL, 32'h1);
        dbl(8'h01);
        drain(400, 4500);
        wr(ADDR_CONTROL, 32'h17);
        dbl(8'h02);
        dbl(8'h04);
        dbl(8'h10);
        drain(1000, 2500);
        wr(ADDR_CONTROL, 32'h1F);
        dbl(8'h08);
        drain(400, 1400);
        dbl(8'h08);
        drain(800, 300);
        wr(ADDR_CONTROL, 32'h0);
        wr(ADDR_CONTROL, 32'h1);
        dbl(8'h01);
        drain(400, 300);
        rdc(ADDR_STATUS, 32'h0000_00A4, 1'b0);
        // a restart alone brings the automatic requests back
        resetn <= 1'b0;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        rdc(ADDR_MODE, 32'h0, 1'b0);
        dbl(8'h08);
        drain(2600, 300);
        summarize();
    end
endmodule // tb_top
